/* pkg/iwd_pkg.sv */
/*
 * constants and types shared by the independent watchdog counter.
 * assumes a single 125 mhz clock and a synchronous active-low reset.
 */
// Behaviour
// - 14-bit down-counter, one step per count tick
// - underflow with reset selected asserts reset output
// - underflow with interrupt selected raises interrupt request
// - auto start counts right after reset release
// - register start waits for first refresh write
package iwd_pkg;
    // ========================================================
    // counter geometry
    localparam int unsigned  CNT_W       = 14;
    localparam logic [13:0]  CNT_INIT    = 14'h3FFF;
    localparam logic [13:0]  CNT_ZERO    = 14'h0000;
    localparam logic [13:0]  CNT_ONE     = 14'h0001;
    // ========================================================
    // count clock prescale, in mclk cycles per count tick
    localparam int unsigned  PRESC_W     = 8;
    localparam logic [7:0]   PRESC_DIV   = 8'h02;
    localparam logic [7:0]   PRESC_ZERO  = 8'h00;
    localparam logic [7:0]   PRESC_ONE   = 8'h01;
    // ========================================================
    // reset output pulse length, in mclk cycles
    localparam logic [3:0]   RST_PULSE   = 4'h8;
    localparam logic [3:0]   RST_ZERO    = 4'h0;
    localparam logic [3:0]   RST_ONE     = 4'h1;
    // ========================================================
    // counter state, gray coded along idle-run-fired
    typedef enum logic [1:0] {
        IWD_IDLE  = 2'b00,
        IWD_RUN   = 2'b01,
        IWD_FIRED = 2'b11
    } iwd_state_type;
endpackage : iwd_pkg

/* rtl/iwd_tick.sv */
/*
 * count tick generator: divides mclk into one-cycle count ticks.
 * assumes enable comes from logic on the same clock.
 */
`timescale 1ns/1ns
module iwd_tick
    import iwd_pkg::*;
(
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  rst_n,
    // control
    input  wire logic  enable,   // run the divider
    input  wire logic  restart,  // realign the tick phase
    // tick out
    output logic       tick      // one-cycle count pulse
);
    logic [7:0] div_reg;  // cycles left to the next tick

    // ========================================================
    // divider: reload on restart, tick when it reaches one
    always_ff @(posedge mclk) begin
        if (!rst_n || restart || !enable) begin
            div_reg <= PRESC_DIV;
        end else if (div_reg == PRESC_ONE) begin
            div_reg <= PRESC_DIV;
        end else begin
            div_reg <= div_reg - PRESC_ONE;
        end
    end

    assign tick = enable && !restart && (div_reg == PRESC_ONE);
endmodule : iwd_tick

/* rtl/iwd_counter.sv */
/*
 * independent watchdog counter: 14-bit down-counter with start
 * mode select, refresh reload and reset or interrupt on underflow.
 * assumes strap inputs are stable while rst_n is low and that the
 * refresh strobe is a one-cycle pulse from logic on mclk.
 */
`timescale 1ns/1ns
module iwd_counter
    import iwd_pkg::*;
(
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // configuration straps, caught at reset release
    input  wire logic         auto_start,   // 1: auto start mode
    input  wire logic         irq_select,   // 1: interrupt, 0: reset
    // software refresh strobe
    input  wire logic         refresh,      // one-cycle write pulse
    // status and events
    output logic [13:0]       count,        // counter value
    output logic              running,      // counting is active
    output logic              reset_out,    // chip reset request
    output logic              irq_out       // underflow interrupt
);
    // ========================================================
    // state
    iwd_state_type state_reg;     // idle, run or fired
    iwd_state_type state_next;
    logic [13:0]   cnt_reg;       // down-counter
    logic          auto_reg;      // latched start mode
    logic          irqsel_reg;    // latched underflow action
    logic          init_reg;      // straps captured after reset
    logic [3:0]    rst_cnt_reg;   // reset pulse remaining
    logic          irq_reg;       // interrupt pulse
    logic          tick;          // count step
    logic          underflow;     // step taken at zero
    logic [1:0]    auto_sync_reg; // strap synchroniser, start mode
    logic [1:0]    irq_sync_reg;  // strap synchroniser, action

    assign underflow = (state_reg == IWD_RUN) && tick
                       && (cnt_reg == CNT_ZERO);

    // ========================================================
    // count tick source
    iwd_tick u_tick (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .enable  (state_reg == IWD_RUN),
        .restart (refresh),
        .tick    (tick)
    );

    // ========================================================
    // strap synchronisers: two flops that run through reset, so
    // the second stage has settled before reset is released
    always_ff @(posedge mclk) begin
        auto_sync_reg <= {auto_sync_reg[0], auto_start};
        irq_sync_reg  <= {irq_sync_reg[0], irq_select};
    end

    // ========================================================
    // strap capture: clocked, first cycle after release
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            init_reg   <= 1'b0;
            auto_reg   <= 1'b0;
            irqsel_reg <= 1'b0;
        end else if (!init_reg) begin
            init_reg   <= 1'b1;
            auto_reg   <= auto_sync_reg[1];
            irqsel_reg <= irq_sync_reg[1];
        end
    end

    // ========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IWD_IDLE: begin
                if (init_reg && auto_reg) begin
                    state_next = IWD_RUN;
                end else if (init_reg && refresh) begin
                    state_next = IWD_RUN;
                end
            end
            IWD_RUN: begin
                // a refresh in the underflow cycle wins over firing
                if (underflow && !refresh && !irqsel_reg) begin
                    state_next = IWD_FIRED;
                end
            end
            IWD_FIRED: begin
                state_next = IWD_FIRED;            // held until reset
            end
            default: begin
                state_next = IWD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= IWD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ========================================================
    // down-counter: reload on refresh, step on tick
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_reg <= CNT_INIT;
        end else if (refresh && state_reg != IWD_FIRED) begin
            cnt_reg <= CNT_INIT;
        end else if (underflow) begin
            cnt_reg <= CNT_INIT;                   // interrupt mode wraps
        end else if (state_reg == IWD_RUN && tick) begin
            cnt_reg <= cnt_reg - CNT_ONE;
        end
    end

    // ========================================================
    // reset output pulse
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rst_cnt_reg <= RST_ZERO;
        end else if (underflow && !refresh && !irqsel_reg) begin
            rst_cnt_reg <= RST_PULSE;
        end else if (rst_cnt_reg != RST_ZERO) begin
            rst_cnt_reg <= rst_cnt_reg - RST_ONE;
        end
    end

    // ========================================================
    // interrupt pulse instead of reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= underflow && !refresh && irqsel_reg;
        end
    end

    // ========================================================
    // outputs: count and irq from flops, running decoded from state, reset from its counter
    assign count     = cnt_reg;
    assign running   = (state_reg == IWD_RUN);
    assign reset_out = (rst_cnt_reg != RST_ZERO);
    assign irq_out   = irq_reg;

    // ========================================================
    // checks
    // a count step taken at zero with no refresh beside it
    sequence under_s;
        underflow && !refresh;
    endsequence

    // the reset request stands for the pulse length, then drops
    sequence rst_pulse_s;
        reset_out [*8] ##1 !reset_out;
    endsequence

    // counting carries on from the top of the range
    sequence wrap_on_s;
        running && cnt_reg == CNT_INIT;
    endsequence

    // each tick away from zero takes one off the count
    step_down_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (running && tick && !refresh && cnt_reg != CNT_ZERO)
        |=> cnt_reg == $past(cnt_reg) - CNT_ONE)
        else $error("counter did not step down");

    // reset mode: underflow starts one reset pulse
    reset_fire_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (under_s and !irqsel_reg) |=> reset_out [*8] ##1 !reset_out)
        else $error("reset pulse wrong");

    // interrupt mode: underflow pulses the request, no reset
    irq_fire_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (under_s and irqsel_reg) |=> irq_out && !reset_out)
        else $error("interrupt not raised");

    // auto start: running one cycle after the straps land
    auto_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ($rose(init_reg) && auto_reg) |=> running)
        else $error("auto start failed");

    // register start: idle holds until a refresh arrives
    reg_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_reg == IWD_IDLE && !auto_reg && init_reg && !refresh)
        |=> !running)
        else $error("started without refresh");

    // register start: the first refresh starts the count
    reg_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_reg == IWD_IDLE && init_reg && refresh) |=> running)
        else $error("refresh did not start counter");

    // every refresh outside the fired state reloads the count
    reload_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (refresh && state_reg != IWD_FIRED) |=> cnt_reg == CNT_INIT)
        else $error("refresh did not reload");

    // a refresh while counting keeps both requests low
    refresh_save_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (running && refresh) |=> !reset_out && !irq_out)
        else $error("refresh did not prevent underflow");

    // any reset request is a whole pulse, never cut short
    rst_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(reset_out) |-> rst_pulse_s)
        else $error("reset pulse length wrong");

    // once fired, a refresh no longer restarts the count
    fired_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_reg == IWD_FIRED && refresh) |=> !running)
        else $error("refresh restarted a fired watchdog");

    // interrupt mode reloads and keeps counting after underflow
    irq_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (under_s and irqsel_reg) |=> wrap_on_s)
        else $error("count did not wrap after interrupt");

    // the interrupt request stands for one cycle only
    irq_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
        irq_out |=> !irq_out && running)
        else $error("interrupt pulse too long");
endmodule : iwd_counter

/* testbench/iwd_counter_tb.sv */
/*
 * self-checking bench for the independent watchdog counter: an integer
 * model of the count is compared with the design's ports.
 * takes the count tick spacing and the start value from iwd_pkg.
 */
`timescale 1ns/1ns
module iwd_counter_tb
    import iwd_pkg::*;
();
    // ========================================================
    // signals
    logic        mclk;        // 125 mhz clock
    logic        rst_n;       // synchronous reset, active low
    logic        auto_start;  // start mode strap
    logic        irq_select;  // underflow action strap
    logic        refresh;     // refresh write strobe
    logic [13:0] count;       // counter value
    logic        running;     // counting active
    logic        reset_out;   // chip reset request
    logic        irq_out;     // underflow interrupt
    logic [31:0] lfsr_reg;    // random source state
    int          errors;      // mismatches seen
    int          num_checks;  // comparisons made
    int          gap;         // random refresh spacing, in cycles
    int          exp_count;   // model count after a random gap

    // device under test
    iwd_counter i_iwd_counter (.mclk(mclk), .rst_n(rst_n),
        .auto_start(auto_start), .irq_select(irq_select),
        .refresh(refresh), .count(count), .running(running),
        .reset_out(reset_out), .irq_out(irq_out));

    // clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ========================================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // wait n edges, then sample once settled
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cycles

    // reset with straps held steady, checking the reset state
    task automatic do_reset(input logic mode, input logic action);
        @(posedge mclk);
        rst_n      <= 1'b0;
        auto_start <= mode;
        irq_select <= action;
        cycles(5);
        check(count, 14'h3FFF);
        check({12'h000, reset_out, irq_out}, 14'h0000);
        @(posedge mclk);
        rst_n <= 1'b1;
        cycles(2);
    endtask : do_reset

    // one-cycle refresh write, sampled one edge after it is taken
    task automatic pulse_refresh();
        @(posedge mclk);
        refresh <= 1'b1;
        @(posedge mclk);
        refresh <= 1'b0;
        cycles(1);
        check(count, 14'h3FFF);
    endtask : pulse_refresh

    // model counts down once per tick; call just after a restart edge
    task automatic track(input int ticks);
        int model_count;
        model_count = int'(CNT_INIT);
        for (int k = 0; k < ticks; k++) begin
            check(count, 14'(model_count));
            check({12'h000, reset_out, irq_out}, 14'h0000);
            model_count--;
            cycles(int'(PRESC_DIV));
        end
    endtask : track

    // runs the count out with no refresh, from one cycle after a
    // refresh edge, then checks the reset or the interrupt pulse
    task automatic expire(input logic action);
        int model_count;
        model_count = int'(CNT_INIT);
        for (int k = 0; k <= int'(CNT_INIT); k++) begin
            check(count, 14'(model_count));
            check({12'h000, reset_out, irq_out}, 14'h0000);
            model_count--;
            if (model_count >= 0) cycles(int'(PRESC_DIV));
        end
        cycles(int'(PRESC_DIV) - 1);
        check(count, CNT_INIT);
        if (action) begin
            check(14'(irq_out), 14'h0001);
            check(14'(reset_out), 14'h0000);
            check(14'(running), 14'h0001);
            cycles(1);
            check(14'(irq_out), 14'h0000);
            cycles(int'(PRESC_DIV) - 1);
            check(count, 14'(int'(CNT_INIT) - 1));
        end else begin
            for (int k = 0; k < int'(RST_PULSE); k++) begin
                check(14'(reset_out), 14'h0001);
                check({12'h000, running, irq_out}, 14'h0000);
                cycles(1);
            end
            check(14'(reset_out), 14'h0000);
        end
    endtask : expire

    // ========================================================
    // main sequence; both underflow actions are run to the end
    initial begin
        rst_n      = 1'b0;
        auto_start = 1'b1;
        irq_select = 1'b0;
        refresh    = 1'b0;
        lfsr_reg   = 32'h9D109A5A;
        errors     = 0;
        num_checks = 0;
        // auto start: counting without any refresh
        do_reset(1'b1, 1'b0);
        check(14'(running), 14'h0001);
        track(3);
        // refresh reload and restart of the count
        pulse_refresh();
        track(3);
        // refreshes at random spacing, never closer than three cycles apart
        for (int i = 0; i < 6; i++) begin
            lfsr_reg = lfsr_next(lfsr_reg);
            gap = int'(lfsr_reg[8:0]) % 300;
            pulse_refresh();
            cycles(gap);
            exp_count = int'(CNT_INIT) - (gap + 1) / int'(PRESC_DIV);
            check(count, 14'(exp_count));
        end
        // reset mode: no refresh until the count runs out
        pulse_refresh();
        expire(1'b0);
        // once fired, a refresh is refused until reset
        pulse_refresh();
        check(14'(running), 14'h0000);
        // register start, interrupt mode: stopped until a refresh
        do_reset(1'b0, 1'b1);
        check(14'(running), 14'h0000);
        cycles(300);
        check(14'(running), 14'h0000);
        check(count, 14'h3FFF);
        pulse_refresh();
        check(14'(running), 14'h0001);
        track(3);
        // interrupt mode: underflow interrupts, counting goes on
        pulse_refresh();
        expire(1'b1);
        report_and_stop();
    end

    // watchdog against a hang, well past the expected run
    initial begin
        #700000;
        errors++;
        report_and_stop();
    end
endmodule : iwd_counter_tb
